// [hdl/ebac_key_check.sv]
// unlock decision: compares the written key with the mirrored stored key
// assumes key bytes and lock enable are registers in the same clock domain
`timescale 1ns/100ps
`default_nettype none
module ebac_key_check (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [7:0]  lock_en,
    input  wire logic [31:0] key,
    input  wire logic [31:0] stored_key,
    output logic             unlocked
);
    import ebac_pkg::*;
    // registered to keep the 32-bit compare off the bus write path
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unlocked <= 1'b0;
        end else begin
            unlocked <= (lock_en != LOCK_ON) || (key == stored_key); // R11
        end
    end
endmodule : ebac_key_check
`default_nettype wire

// [hdl/ebac_nvm_seq.sv]
// sequencer toward the nvm array: holds a request until the array acks
// assumes the array answers each request with one ack pulse
`timescale 1ns/100ps
`default_nettype none
module ebac_nvm_seq (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    ebac_cmd_if.eng         cmd,
    output logic            nvm_req,
    output logic [1:0]      nvm_op,
    output logic [7:0]      nvm_addr,
    output logic [7:0]      nvm_wdata,
    input  wire logic       nvm_ack,
    input  wire logic [7:0] nvm_rdata,
    input  wire logic       nvm_err
);
    import ebac_pkg::*;
    typedef enum logic {ENG_IDLE, ENG_BUSY} ebac_eng_t;
    ebac_eng_t state_q;
    ebac_op_t  op_q;

    // request held from accepted start to ack
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ENG_IDLE;
            op_q    <= OP_UPDATE_ALL;
            nvm_req <= 1'b0;
            nvm_op  <= 2'h0;
            nvm_addr <= 8'h00;
            nvm_wdata <= 8'h00;
        end else begin
            case (state_q)
                ENG_IDLE: if (cmd.start) begin
                    state_q   <= ENG_BUSY;
                    op_q      <= cmd.op;
                    nvm_req   <= 1'b1;
                    nvm_op    <= cmd.op;
                    nvm_addr  <= cmd.addr;
                    nvm_wdata <= cmd.wdata; // R3
                end
                ENG_BUSY: if (nvm_ack) begin
                    state_q <= ENG_IDLE;
                    nvm_req <= 1'b0;
                end
                default: state_q <= ENG_IDLE;
            endcase
        end
    end

    // completion pulses and pending level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd.pending  <= 1'b0;
            cmd.done     <= 1'b0;
            cmd.rd_valid <= 1'b0;
            cmd.rdata    <= 8'h00;
            cmd.fail     <= 1'b0;
        end else begin
            cmd.done     <= (state_q == ENG_BUSY) && nvm_ack;
            cmd.rd_valid <= (state_q == ENG_BUSY) && nvm_ack &&
                            (op_q == OP_READ_BYTE);
            cmd.fail     <= (state_q == ENG_BUSY) && nvm_ack && nvm_err &&
                            (op_q != OP_READ_BYTE) &&
                            (op_q != OP_REFRESH_ALL); // R7
            if ((state_q == ENG_BUSY) && nvm_ack) begin
                cmd.rdata <= nvm_rdata;
            end
            if (cmd.start && (state_q == ENG_IDLE)) begin
                cmd.pending <= 1'b1; // R12
            end else if ((state_q == ENG_BUSY) && nvm_ack) begin
                cmd.pending <= 1'b0; // R12
            end
        end
    end
endmodule : ebac_nvm_seq
`default_nettype wire

// [hdl/ebac_top.sv]
// nvm byte access control: ahb-lite register front end, lock, interrupts
// assumes a single ahb-lite master, one slave on the bus, word transfers
`timescale 1ns/100ps
`default_nettype none
module ebac_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq,
    output logic             auto_refresh_inhibit,
    output logic             nvm_transfer_pending,
    output logic             nvm_write_fail_flag,
    input  wire logic [31:0] stored_key,
    output logic             nvm_req,
    output logic [1:0]       nvm_op,
    output logic [7:0]       nvm_addr,
    output logic [7:0]       nvm_wdata,
    input  wire logic        nvm_ack,
    input  wire logic [7:0]  nvm_rdata,
    input  wire logic        nvm_err
);
    import ebac_pkg::*;

    ebac_cmd_if cmd_bus ();

    // bus data phase state
    logic             dph_act_q;
    logic             dph_wr_q;
    logic [7:0]       dph_idx_q;
    // registers
    logic [7:0]       nvm_byte_value_q;
    logic [7:0]       nvm_byte_pointer_q;
    logic [7:0]       write_lock_enable_q;
    logic [31:0]      unlock_key_q;
    logic             ctrl_inhibit_q;
    logic [INT_W-1:0] int_sts_q;
    logic [INT_W-1:0] int_mask_q;
    logic             unlocked;
    // decoded strobes
    logic             wr_en;
    logic [7:0]       wbyte;
    logic             prot_ok;
    logic             cmd_go;
    logic [INT_W-1:0] int_set;
    logic [INT_W-1:0] int_clr;

    ebac_key_check u_key (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .lock_en    (write_lock_enable_q),
        .key        (unlock_key_q),
        .stored_key (stored_key),
        .unlocked   (unlocked)
    );

    ebac_nvm_seq u_seq (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .cmd       (cmd_bus.eng),
        .nvm_req   (nvm_req),
        .nvm_op    (nvm_op),
        .nvm_addr  (nvm_addr),
        .nvm_wdata (nvm_wdata),
        .nvm_ack   (nvm_ack),
        .nvm_rdata (nvm_rdata),
        .nvm_err   (nvm_err)
    );

    // read mux, shared by the address phase; write-only words read zero
    function automatic logic [7:0] rd_mux(input logic [7:0] idx);
        case (idx)
            IDX_LOCK_EN:  return write_lock_enable_q;
            IDX_CTRL:     return {7'h00, ctrl_inhibit_q};
            IDX_STATUS:   return {6'h00, int_sts_q[INT_FAIL],
                                  cmd_bus.pending};
            IDX_INT_STS:  return {6'h00, int_sts_q};
            IDX_INT_MASK: return {6'h00, int_mask_q};
            IDX_PTR:      return nvm_byte_pointer_q;
            IDX_DATA:     return nvm_byte_value_q;
            default:      return BYTE_ZERO;
        endcase
    endfunction : rd_mux

    // data phase strobes; registers use the low byte of hwdata
    assign wr_en   = dph_act_q && dph_wr_q;
    assign wbyte   = hwdata[7:0];
    assign prot_ok = unlocked;

    // a command is accepted only when valid, unlocked and nothing pending
    assign cmd_go = wr_en && (dph_idx_q == IDX_CMD) && prot_ok &&
                    ebac_valid_cmd(wbyte) && !cmd_bus.pending; // R4 R9 R6
    assign cmd_bus.start = cmd_go;
    assign cmd_bus.op    = ebac_cmd_op(wbyte);
    assign cmd_bus.addr  = nvm_byte_pointer_q; // R10
    assign cmd_bus.wdata = nvm_byte_value_q;   // R3

    // interrupt set and write-one-to-clear terms
    assign int_set = {cmd_bus.fail, cmd_bus.done};
    assign int_clr = (wr_en && (dph_idx_q == IDX_INT_STS)) ?
                     wbyte[INT_W-1:0] : {INT_W{1'b0}};

    // address phase capture; the slave never inserts wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_act_q <= 1'b0;
            dph_wr_q  <= 1'b0;
            dph_idx_q <= 8'h00;
        end else if (hready) begin
            dph_act_q <= hsel && htrans[1];
            dph_wr_q  <= hwrite;
            dph_idx_q <= haddr[9:2];
        end
    end

    // read data registered at the address phase so it stands in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= {24'h00_0000, rd_mux(haddr[9:2])}; // R2 R9
        end
    end

    // always ready and always okay, since every access completes at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
    end

    // data port: a finished byte read wins over a software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nvm_byte_value_q <= DATA_RST; // R1
        end else if (cmd_bus.rd_valid) begin
            nvm_byte_value_q <= cmd_bus.rdata; // R3
        end else if (wr_en && (dph_idx_q == IDX_DATA) && prot_ok) begin
            nvm_byte_value_q <= wbyte; // R2
        end
    end

    // byte pointer, protected like the data port
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nvm_byte_pointer_q <= PTR_RST; // R10
        end else if (wr_en && (dph_idx_q == IDX_PTR) && prot_ok) begin
            nvm_byte_pointer_q <= wbyte; // R10
        end
    end

    // key bytes are always writable, otherwise the lock could never open
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unlock_key_q <= 32'h0000_0000;
        end else if (wr_en) begin
            case (dph_idx_q)
                IDX_KEY0: unlock_key_q[7:0]   <= wbyte; // R11
                IDX_KEY1: unlock_key_q[15:8]  <= wbyte;
                IDX_KEY2: unlock_key_q[23:16] <= wbyte;
                IDX_KEY3: unlock_key_q[31:24] <= wbyte;
                default:  unlock_key_q        <= unlock_key_q;
            endcase
        end
    end

    // lock enable is itself protected once the lock is armed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            write_lock_enable_q <= 8'h00;
        end else if (wr_en && (dph_idx_q == IDX_LOCK_EN) && prot_ok) begin
            write_lock_enable_q <= wbyte; // R11
        end
    end

    // control and interrupt mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_inhibit_q <= 1'b0;
            int_mask_q     <= {INT_W{1'b0}};
        end else if (wr_en) begin
            if (dph_idx_q == IDX_CTRL) begin
                ctrl_inhibit_q <= wbyte[CTRL_INHIBIT]; // R5
            end
            if (dph_idx_q == IDX_INT_MASK) begin
                int_mask_q <= wbyte[INT_W-1:0];
            end
        end
    end

    // sticky events: a set in the clearing cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_sts_q <= {INT_W{1'b0}};
        end else begin
            int_sts_q <= (int_sts_q & ~int_clr) | int_set; // R7
        end
    end

    // outputs straight from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq                  <= 1'b0;
            auto_refresh_inhibit <= 1'b0;
            nvm_transfer_pending <= 1'b0;
            nvm_write_fail_flag  <= 1'b0;
        end else begin
            irq                  <= |(int_sts_q & int_mask_q);
            auto_refresh_inhibit <= ctrl_inhibit_q; // R5
            nvm_transfer_pending <= cmd_bus.pending; // R12
            nvm_write_fail_flag  <= int_sts_q[INT_FAIL]; // R7
        end
    end

    // checks of the front end against its sequencer
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // named steps shared by the properties below
    sequence s_cmd_rd_addr;
        hready && hsel && htrans[1] && !hwrite && (haddr[9:2] == IDX_CMD);
    endsequence

    sequence s_locked_data_wr;
        wr_en && (dph_idx_q == IDX_DATA) && !prot_ok && !cmd_bus.rd_valid;
    endsequence

    sequence s_locked_ptr_wr;
        wr_en && (dph_idx_q == IDX_PTR) && !prot_ok;
    endsequence

    sequence s_bad_cmd_idle;
        wr_en && (dph_idx_q == IDX_CMD) && !ebac_valid_cmd(wbyte) &&
        !cmd_bus.pending;
    endsequence

    // a waiting request must not move under the array
    sequence s_req_waiting;
        nvm_req && !nvm_ack;
    endsequence

    AST_CMD_READS_ZERO: assert property ( // R9
        s_cmd_rd_addr |=> (hrdata == 32'h0000_0000))
        else $error("command register read returned nonzero");

    AST_LOCKED_DATA_HOLD: assert property ( // R2
        s_locked_data_wr |=> $stable(nvm_byte_value_q))
        else $error("data port changed while write locked");

    AST_START_PENDING: assert property ( // R12
        cmd_go |=> cmd_bus.pending ##1 nvm_transfer_pending)
        else $error("pending not raised after accepted command");

    AST_PENDING_HOLD: assert property ( // R12
        (cmd_bus.pending && !nvm_ack) |=> cmd_bus.pending)
        else $error("pending dropped before nvm ack");

    AST_PENDING_CLEAR: assert property ( // R12
        (cmd_bus.pending && nvm_req && nvm_ack) |=> !cmd_bus.pending)
        else $error("pending not cleared after nvm ack");

    AST_READ_LOADS: assert property ( // R3
        (nvm_req && nvm_ack && (nvm_op == OP_READ_BYTE)) |=> ##1
        (nvm_byte_value_q == $past(nvm_rdata, 2)))
        else $error("byte read did not load the data port");

    AST_WRITE_DRIVES: assert property ( // R3
        (cmd_go && (cmd_bus.op == OP_WRITE_BYTE)) |=>
        (nvm_wdata == $past(nvm_byte_value_q)) &&
        (nvm_addr == $past(nvm_byte_pointer_q)))
        else $error("byte write did not carry data port and pointer");

    AST_FAIL_FLAG: assert property ( // R7
        (nvm_req && nvm_ack && nvm_err && (nvm_op == OP_WRITE_BYTE))
        |=> ##2 nvm_write_fail_flag)
        else $error("write failure did not raise the fail flag");

    AST_BAD_CMD_IGNORED: assert property ( // R4
        s_bad_cmd_idle |=> !cmd_bus.pending)
        else $error("invalid command code started an operation");

    AST_LOCK_BLOCKS_CMD: assert property ( // R11
        (wr_en && (dph_idx_q == IDX_CMD) && !prot_ok) |-> !cmd_go)
        else $error("command accepted while write locked");

    // further checks: bus, lock, request, flag and interrupt
    AST_RDATA_HIGH_ZERO: assert property (
        hrdata[31:8] == 24'h00_0000)
        else $error("read data has bits above the byte");

    AST_ALWAYS_READY: assert property (
        hreadyout && (hresp == HRESP_OKAY))
        else $error("slave stalled or gave an error");

    AST_LOCKED_PTR_HOLD: assert property ( // R10
        s_locked_ptr_wr |=> $stable(nvm_byte_pointer_q))
        else $error("pointer changed while write locked");

    AST_LOCKED_EN_HOLD: assert property ( // R11
        (wr_en && (dph_idx_q == IDX_LOCK_EN) && !prot_ok) |=>
        $stable(write_lock_enable_q))
        else $error("lock enable changed while write locked");

    AST_REQ_HOLDS: assert property ( // R3
        s_req_waiting |=> nvm_req && $stable(nvm_addr) && $stable(nvm_wdata))
        else $error("request moved before its ack");

    AST_REQ_DROPS: assert property ( // R12
        (nvm_req && nvm_ack) |=> !nvm_req)
        else $error("request held after its ack");

    AST_PENDING_OUT: assert property ( // R12
        cmd_bus.pending |=> nvm_transfer_pending)
        else $error("pending output did not follow");

    AST_FAIL_SET_WINS: assert property ( // R7
        cmd_bus.fail |=> int_sts_q[INT_FAIL])
        else $error("write failure lost in a clearing cycle");

    AST_FAIL_STICKY: assert property ( // R7
        (int_sts_q[INT_FAIL] && !int_clr[INT_FAIL]) |=> int_sts_q[INT_FAIL])
        else $error("fail flag dropped without a clear");

    AST_IRQ_RAISE: assert property (
        (|(int_sts_q & int_mask_q)) |=> irq)
        else $error("irq low with an unmasked event");

    AST_IRQ_LOWER: assert property (
        !(|(int_sts_q & int_mask_q)) |=> !irq)
        else $error("irq high with no unmasked event");
endmodule : ebac_top
`default_nettype wire

// [pkg/ebac_cmd_if.sv]
// command carrier between register front end and nvm sequencer
// assumes both ends run on hclk
`timescale 1ns/100ps
`default_nettype none
interface ebac_cmd_if;
    import ebac_pkg::*;
    logic           start;
    ebac_op_t       op;
    logic [7:0]     addr;
    logic [7:0]     wdata;
    logic           pending;
    logic           done;
    logic           rd_valid;
    logic [7:0]     rdata;
    logic           fail;
    modport ctl (output start, op, addr, wdata,
                 input  pending, done, rd_valid, rdata, fail);
    modport eng (input  start, op, addr, wdata,
                 output pending, done, rd_valid, rdata, fail);
endinterface : ebac_cmd_if
`default_nettype wire

// [pkg/ebac_pkg.sv]
// package for the nvm byte access control block: register map, codes, fields
// assumes an ahb-lite slave with word-aligned registers (byte addr = idx*4)
// What this block does
// [R1] eight-bit data port register carrying one nvm byte, reset to zero
// [R2] data port always readable; writes blocked while write lock is active
// [R3] byte read fills data port; byte write stores data port into nvm
// [R4] valid command code starts update-all, refresh-all, byte read or write
// [R5] host sets auto refresh inhibit before any nvm command
// [R6] host issues a new command only when transfer pending reads zero
// [R7] failed nvm write sets the write fail flag
// [R8] host writes only codes 11h, 12h, 21h or 22h as commands
// [R9] command register is write only, reads zero, and is lock protected
// [R10] byte pointer selects nvm location, resets to c0h
// [R11] with lock enable 255 the correct 32-bit key must unlock writes
// [R12] transfer pending rises on accepted command, falls when operation ends
`default_nettype none
package ebac_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_LOCK_EN  = 8'h30;
    localparam logic [7:0] IDX_CTRL     = 8'h31;
    localparam logic [7:0] IDX_STATUS   = 8'h32;
    localparam logic [7:0] IDX_INT_STS  = 8'h33;
    localparam logic [7:0] IDX_INT_MASK = 8'h34;
    localparam logic [7:0] IDX_KEY0     = 8'h39;
    localparam logic [7:0] IDX_KEY1     = 8'h3a;
    localparam logic [7:0] IDX_KEY2     = 8'h3b;
    localparam logic [7:0] IDX_KEY3     = 8'h3c;
    localparam logic [7:0] IDX_PTR      = 8'h3d;
    localparam logic [7:0] IDX_DATA     = 8'h3e;
    localparam logic [7:0] IDX_CMD      = 8'h3f;
    // reset values, read-zero byte and lock-on code
    localparam logic [7:0] PTR_RST   = 8'hc0;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] LOCK_ON   = 8'hff;
    // command codes
    localparam logic [7:0] CMD_UPDATE_ALL  = 8'h11;
    localparam logic [7:0] CMD_REFRESH_ALL = 8'h12;
    localparam logic [7:0] CMD_WRITE_BYTE  = 8'h21;
    localparam logic [7:0] CMD_READ_BYTE   = 8'h22;
    // field positions
    localparam int unsigned CTRL_INHIBIT = 0;
    localparam int unsigned ST_PENDING   = 0;
    localparam int unsigned ST_FAIL      = 1;
    localparam int unsigned INT_DONE     = 0;
    localparam int unsigned INT_FAIL     = 1;
    localparam int unsigned INT_W        = 2;
    localparam logic        HRESP_OKAY   = 1'b0;

    typedef enum logic [1:0] {
        OP_UPDATE_ALL, OP_REFRESH_ALL, OP_WRITE_BYTE, OP_READ_BYTE
    } ebac_op_t;

    // true for the four codes that start an operation
    function automatic logic ebac_valid_cmd(input logic [7:0] code);
        return (code == CMD_UPDATE_ALL) || (code == CMD_REFRESH_ALL) ||
               (code == CMD_WRITE_BYTE) || (code == CMD_READ_BYTE);
    endfunction : ebac_valid_cmd

    function automatic ebac_op_t ebac_cmd_op(input logic [7:0] code);
        case (code)
            CMD_UPDATE_ALL:  return OP_UPDATE_ALL;
            CMD_REFRESH_ALL: return OP_REFRESH_ALL;
            CMD_WRITE_BYTE:  return OP_WRITE_BYTE;
            default:         return OP_READ_BYTE;
        endcase
    endfunction : ebac_cmd_op
endpackage : ebac_pkg
`default_nettype wire

// [verification/ebac_nvm_model.sv]
// nvm array model: answers each request with one ack after a set wait
// assumes the sequencer holds its request until it samples the ack
`timescale 1ns/100ps
`default_nettype none
module ebac_nvm_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       nvm_req,
    input  wire logic [1:0] nvm_op,
    input  wire logic [7:0] nvm_addr,
    input  wire logic [7:0] nvm_wdata,
    input  wire logic [3:0] ack_wait,
    input  wire logic       fail_next,
    output logic            nvm_ack,
    output logic [7:0]      nvm_rdata,
    output logic            nvm_err
);
    logic [7:0] mem [256];
    logic [3:0] cnt_q;

    // preload a pattern the bench can predict (byte = addr ^ 3c)
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h3c;
        end
    end

    // one ack pulse per request; outside it the data lines keep changing
    // so a late sample never sees a stale byte by luck
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nvm_ack   <= 1'b0;
            nvm_err   <= 1'b0;
            nvm_rdata <= 8'h96;
            cnt_q     <= 4'h0;
        end else if (nvm_req && !nvm_ack && cnt_q >= ack_wait) begin
            nvm_ack   <= 1'b1;
            nvm_err   <= fail_next && !nvm_op[0];
            nvm_rdata <= mem[nvm_addr];
            cnt_q     <= 4'h0;
            if (nvm_op == 2'd2 && !fail_next) begin
                mem[nvm_addr] <= nvm_wdata;
            end
        end else begin
            nvm_ack   <= 1'b0;
            nvm_err   <= ~nvm_err;
            nvm_rdata <= ~nvm_rdata;
            cnt_q     <= nvm_req ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule : ebac_nvm_model
`default_nettype wire

// [verification/tb_top.sv]
// bench for the nvm byte access block: ahb-lite host tasks and array model
// assumes the register map and command codes of ebac_pkg
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ebac_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        irq, auto_refresh_inhibit, nvm_transfer_pending;
    logic        nvm_write_fail_flag, nvm_req, nvm_ack, nvm_err, fail_next;
    logic [1:0]  htrans, nvm_op;
    logic [2:0]  hsize;
    logic [3:0]  ack_wait;
    logic [7:0]  nvm_addr, nvm_wdata, nvm_rdata;
    logic [31:0] haddr, hwdata, hrdata, stored_key, rdv;
    logic [7:0]  codes [4];
    int          n_fail, checks, cyc, i;

    assign hready = hreadyout;

    ebac_top u_ebac_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq,
        .auto_refresh_inhibit, .nvm_transfer_pending, .nvm_write_fail_flag,
        .stored_key, .nvm_req, .nvm_op, .nvm_addr, .nvm_wdata, .nvm_ack,
        .nvm_rdata, .nvm_err);

    ebac_nvm_model u_ebac_nvm_model (.hclk, .hresetn, .nvm_req, .nvm_op,
        .nvm_addr, .nvm_wdata, .ack_wait, .fail_next, .nvm_ack, .nvm_rdata,
        .nvm_err);

    // 20 MHz clock
    always #25 hclk = ~hclk;

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one single ahb-lite transfer; hready is sampled, never assumed
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, {24'h0, d});
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(rdv, {24'h0, exp});
    endtask : rdc

    // poll until idle, then let the fixed result lags settle
    task automatic wait_idle;
        for (int k = 0; k < 40; k++) begin
            bus(1'b0, IDX_STATUS, 32'h0);
            if (rdv[ST_PENDING] === 1'b0) break;
        end
        repeat (4) @(posedge hclk);
    endtask : wait_idle

    task automatic wrap_up;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    // main sequence
    initial begin
        hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00;
        haddr = 32'h0; hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0;
        stored_key = 32'h5aa5c33c; ack_wait = 4'h2; fail_next = 1'b0;
        codes = '{CMD_UPDATE_ALL, CMD_REFRESH_ALL, CMD_WRITE_BYTE,
                  CMD_READ_BYTE};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(IDX_DATA, DATA_RST);
        rdc(IDX_PTR, PTR_RST);
        rdc(IDX_CMD, BYTE_ZERO);
        rdc(IDX_KEY0, BYTE_ZERO);
        rdc(8'h00, BYTE_ZERO);
        wr(IDX_DATA, 8'ha5);
        rdc(IDX_DATA, 8'ha5);
        wr(IDX_CMD, 8'h33);
        rdc(IDX_STATUS, 8'h00);
        rdc(IDX_CMD, 8'h00);
        wr(IDX_CTRL, 8'h01);
        wr(IDX_INT_MASK, 8'h03);
        rdc(IDX_INT_MASK, 8'h03);
        chk(32'(auto_refresh_inhibit), 32'h1);
        // every code; the op must stand on the link during the request
        for (i = 0; i < 4; i++) begin
            wr(IDX_PTR, 8'h10 + 8'(i));
            wr(IDX_DATA, 8'h70 + 8'(i));
            wr(IDX_CMD, codes[i]);
            @(posedge hclk);
            #1;
            chk(32'(nvm_op), 32'(i));
            chk(32'(nvm_req), 32'h1);
            chk(32'(nvm_wdata), 32'h70 + 32'(i));
            chk(32'(nvm_transfer_pending), 32'h1);
            wait_idle();
            chk(32'(nvm_transfer_pending), 32'h0);
        end
        rdc(IDX_DATA, 8'h2f);
        wr(IDX_PTR, 8'h12);
        wr(IDX_CMD, CMD_READ_BYTE);
        wait_idle();
        rdc(IDX_DATA, 8'h72);
        // done event raises the interrupt; write one clears it
        rdc(IDX_INT_STS, 8'h01);
        chk(32'(irq), 32'h1);
        wr(IDX_INT_STS, 8'h01);
        rdc(IDX_INT_STS, 8'h00);
        chk(32'(irq), 32'h0);
        // a second command while one is pending is dropped
        ack_wait <= 4'hf;
        wr(IDX_PTR, 8'h20);
        wr(IDX_CMD, CMD_READ_BYTE);
        wr(IDX_CMD, CMD_WRITE_BYTE);
        #1;
        chk(32'(nvm_op), 32'h3);
        chk(32'(nvm_addr), 32'h20);
        wait_idle();
        rdc(IDX_DATA, 8'h1c);
        // failed write sets the flag; masking hides it from irq
        ack_wait <= 4'h1;
        fail_next <= 1'b1;
        wr(IDX_CMD, CMD_WRITE_BYTE);
        wait_idle();
        rdc(IDX_STATUS, 8'h02);
        chk(32'(nvm_write_fail_flag), 32'h1);
        chk(32'(irq), 32'h1);
        wr(IDX_INT_MASK, 8'h00);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0);
        wr(IDX_INT_STS, 8'h03);
        rdc(IDX_STATUS, 8'h00);
        fail_next <= 1'b0;
        // write lock: protected writes dropped until the key matches
        wr(IDX_LOCK_EN, LOCK_ON);
        rdc(IDX_LOCK_EN, LOCK_ON);
        wr(IDX_DATA, 8'h55);
        rdc(IDX_DATA, 8'h1c);
        wr(IDX_CMD, CMD_READ_BYTE);
        rdc(IDX_STATUS, 8'h00);
        wr(IDX_PTR, 8'h00);
        rdc(IDX_PTR, 8'h20);
        wr(IDX_LOCK_EN, 8'h00);
        rdc(IDX_LOCK_EN, LOCK_ON);
        for (i = 0; i < 4; i++) begin
            wr(IDX_KEY0 + 8'(i), stored_key[8*i +: 8]);
        end
        repeat (2) @(posedge hclk);
        wr(IDX_DATA, 8'h55);
        rdc(IDX_DATA, 8'h55);
        rdc(IDX_KEY1, BYTE_ZERO);
        chk(32'(hresp), 32'(HRESP_OKAY));
        chk(32'(hreadyout), 32'h1);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
